// file: pkg/scl_pkg.sv
/*
 * scl_pkg: constants, field positions and carrier types shared by the
 * synthesizer control latch logic and its helpers.
 * assumes: a 21-bit serial word whose two low bits name the target latch.
 */
package scl_pkg;
   localparam int unsigned SCL_WORD_W = 21;         // serial word width
   localparam int unsigned SCL_DATA_W = 19;         // latch payload, word bits 20..2
   localparam int unsigned SCL_SYNC_STAGES = 2;     // flops per synchroniser
   // destination codes carried in word bits 1..0
   localparam logic [1:0] SCL_DEST_REF = 2'h0;
   localparam logic [1:0] SCL_DEST_FB = 2'h1;
   localparam logic [1:0] SCL_DEST_FUNC = 2'h2;
   localparam logic [1:0] SCL_DEST_INIT = 2'h3;
   // function/init latch bit positions within the 21-bit word
   localparam int unsigned SCL_POS_HOLD = 2;        // counter_hold_bit
   localparam int unsigned SCL_POS_PD_REQ = 3;      // powerdown_request_bit
   localparam int unsigned SCL_POS_OBS_LO = 4;      // observe_select_b0
   localparam int unsigned SCL_POS_POLARITY = 7;    // detector_polarity_bit
   localparam int unsigned SCL_POS_PUMP_TRI = 8;    // pump three-state bit
   localparam int unsigned SCL_POS_FA_EN = 9;       // fast acquisition enable
   localparam int unsigned SCL_POS_FA_MODE = 11;    // fast acquisition mode
   localparam int unsigned SCL_POS_TO_LO = 12;      // timeout_code_lsb
   localparam int unsigned SCL_POS_PD_SYNC = 19;    // powerdown_sync_select
   // pump_gain_bit position inside the stored feedback payload (word bit 20)
   localparam int unsigned SCL_POS_GAIN = 18;
   // timeout = base + step * code, in phase_comparator cycles
   localparam logic [5:0] SCL_TO_BASE = 6'h03;
   localparam int unsigned SCL_TO_STEP_SHIFT = 2;
   // observe output select codes, in listed order
   localparam logic [2:0] SCL_OBS_TRI = 3'h0;
   localparam logic [2:0] SCL_OBS_LOCK = 3'h1;
   localparam logic [2:0] SCL_OBS_FB = 3'h2;
   localparam logic [2:0] SCL_OBS_REF = 3'h3;
   localparam logic [2:0] SCL_OBS_LOCK_OD = 3'h4;
   localparam logic [2:0] SCL_OBS_SDO = 3'h5;
   localparam logic [2:0] SCL_OBS_GND = 3'h6;
   // decoded function settings
   typedef struct packed {
      logic pd_sync;          // powerdown_sync_select
      logic [3:0] timeout;    // timeout code
      logic fa_mode;          // 0 manual exit, 1 timed exit
      logic fa_en;            // fast acquisition enable
      logic pump_tri;         // pump three-state request
      logic polarity;         // detector_polarity_bit
      logic [2:0] obs_sel;    // observe select
      logic pd_req;           // powerdown_request_bit
      logic hold;             // counter_hold_bit
   } scl_func_s;
   localparam scl_func_s SCL_FUNC_RST = '0;
   // charge pump controls
   typedef struct packed {
      logic tristate;         // 1: pump output high impedance
      logic high_current;     // 1: high current, 0: low current
      logic positive;         // 1: positive detector sense
   } scl_pump_s;
   localparam scl_pump_s SCL_PUMP_RST = 3'h4;
   // power state from the programmed bits
   typedef enum logic [2:0] {
      SCL_PWR_ON = 3'h1,
      SCL_PWR_WAIT = 3'h2,
      SCL_PWR_DOWN = 3'h4
   } scl_pwr_e;
endpackage

// file: src/scl_sync.sv
/*
 * scl_sync: plain multi-bit two-flop synchroniser, one lane per bit.
 * assumes: each lane is an independent level; no word coherence is implied.
 */
`timescale 1ns/100ps
module scl_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import scl_pkg::*;
   logic [W-1:0] meta; // first stage, read only by q

   // two stages per lane
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// file: src/scl_shifter.sv
/*
 * scl_shifter: serial input register on the link clock.
 * assumes: the host holds the link clock still while the load strobe is
 * high, so the word is stable whenever the system side copies it.
 */
`timescale 1ns/100ps
module scl_shifter (
   input wire logic ser_clk,
   input wire logic rst_b,
   input wire logic ser_data,
   output logic [scl_pkg::SCL_WORD_W-1:0] word
);
   import scl_pkg::*;

   // msb first: each rising link edge moves the word up one place
   always_ff @(posedge ser_clk or negedge rst_b) begin
      if (!rst_b) begin
         word <= '0;
      end else begin
         word <= {word[SCL_WORD_W-2:0], ser_data};
      end
   end
endmodule

// file: src/scl_latch_ctrl.sv
/*
 * scl_latch_ctrl: control latches of the synthesizer. Decodes serial words
 * into the reference, feedback, function and init latches, and runs the
 * power-down modes, fast acquisition timer, reset pulse and observe mux.
 * assumes: counter datapath and analog stages sit outside; their status
 * lines arrive as asynchronous pins and are synchronised here.
 */
// Function
// - low two bits pick the destination latch
// - hold bit drives counter reset, not timeout reload
// - power enable low powers down at once
// - request with sync select 0 powers down now
// - request with sync select 1 waits pump event
// - power-down resets counters, tristates pump, lock
// - three-bit select routes the observe output
// - polarity bit picks positive or negative sense
// - pump three-state bit floats pump output
// - fast acquisition only when enable bit set
// - mode bit picks manual or timed exit
// - disabled: switch output follows mode bit
// - mode one: gain bit drives switch low
// - mode two: timeout clears stored gain bit
// - timeout is three plus four times code
// - otherwise gain bit picks pump current
// - init load updates settings, fires reset pulse
// - init load with sync power-down starts it
// - first feedback load after init pulses again
// - hold bit never starts synchronous power-down
// - serial word shifts in msb first
// - load strobe rise copies word to latch
`timescale 1ns/100ps
module scl_latch_ctrl (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic load_strobe,
   input wire logic power_enable,
   input wire logic ref_div_in,
   input wire logic fb_div_in,
   input wire logic lock_detect_in,
   input wire logic pump_event_in,
   input wire logic pd_cycle_in,
   output logic [scl_pkg::SCL_DATA_W-1:0] ref_latch_word,
   output logic [scl_pkg::SCL_DATA_W-1:0] fb_latch_word,
   output scl_pkg::scl_pump_s pump_ctrl,
   output logic counter_reset,
   output logic timeout_reload,
   output logic powered_down,
   output logic lock_detect_reset,
   output logic fast_active,
   output logic loop_filter_switch_out,
   output logic observe_output,
   output logic observe_oe_b
);
   import scl_pkg::*;

   // clock domain map: only the shifter runs on ser_clk, every latch below
   // runs on sys_clk; the word itself passes no synchroniser because it is
   // quiet whenever the synchronised strobe edge lets this side copy it,
   // which leans on the host keeping the link clock still around the strobe
   // link side word, only copied while the strobe stands high
   logic [SCL_WORD_W-1:0] shift_word;
   // synchronised pins
   logic [6:0] pin_raw;
   logic [6:0] pin_s;
   wire le_s = pin_s[6];
   wire ce_s = pin_s[5];
   wire ref_s = pin_s[4];
   wire fb_s = pin_s[3];
   wire lock_s = pin_s[2];
   wire pump_s = pin_s[1];
   wire cyc_s = pin_s[0];
   // serial data output tap, crosses separately
   logic sdo_s;
   // edge memories of synchronised levels
   logic le_d;
   logic pump_d;
   logic cyc_d;
   // latch contents
   scl_func_s func;
   scl_pwr_e pwr;
   scl_pwr_e next_pwr;
   logic arm_fb_pulse;   // next feedback load fires the reset pulse
   logic rst_pulse;      // internal counter reset pulse, one cycle
   logic [5:0] fa_count; // timeout countdown in comparator cycles
   logic fa_run;         // timed exit armed

   // link-domain shift register
   scl_shifter u_shift (
      .ser_clk(ser_clk),
      .rst_b(rst_b),
      .ser_data(ser_data),
      .word(shift_word)
   );

   // datapath status lines are asynchronous to sys_clk; one bundle keeps
   // them in a single synchroniser instance, lane by lane
   assign pin_raw = {load_strobe, power_enable, ref_div_in, fb_div_in,
                     lock_detect_in, pump_event_in, pd_cycle_in};

   // every pin of this bundle passes two flops before any logic reads it
   scl_sync #(.W(7)) u_pin_sync (
      .clk(sys_clk),
      .rst_b(rst_b),
      .d(pin_raw),
      .q(pin_s)
   );

   // msb of the shift register shown as serial data out
   scl_sync #(.W(1)) u_sdo_sync (
      .clk(sys_clk),
      .rst_b(rst_b),
      .d(shift_word[SCL_WORD_W-1]),
      .q(sdo_s)
   );

   // decode of a word into function settings, shared by two latch codes
   function automatic scl_func_s decode_func(input logic [SCL_WORD_W-1:0] w);
      scl_func_s f;
      f.hold = w[SCL_POS_HOLD];
      f.pd_req = w[SCL_POS_PD_REQ];
      f.obs_sel = w[SCL_POS_OBS_LO +: 3];
      f.polarity = w[SCL_POS_POLARITY];
      f.pump_tri = w[SCL_POS_PUMP_TRI];
      f.fa_en = w[SCL_POS_FA_EN];
      f.fa_mode = w[SCL_POS_FA_MODE];
      f.timeout = w[SCL_POS_TO_LO +: 4];
      f.pd_sync = w[SCL_POS_PD_SYNC];
      return f;
   endfunction

   // events
   wire le_rise = le_s & ~le_d;
   wire pump_rise = pump_s & ~pump_d;
   wire cyc_rise = cyc_s & ~cyc_d;
   wire [1:0] dest = shift_word[1:0];
   wire load_ref = le_rise & (dest == SCL_DEST_REF);
   wire load_fb = le_rise & (dest == SCL_DEST_FB);
   wire load_init = le_rise & (dest == SCL_DEST_INIT);
   wire load_func = le_rise & ((dest == SCL_DEST_FUNC) | load_init);
   wire [SCL_DATA_W-1:0] payload = shift_word[SCL_WORD_W-1:2];
   wire scl_func_s new_func = decode_func(shift_word);

   // pulse on init load, and on the first feedback load after it
   wire next_rst_pulse = load_init | (load_fb & arm_fb_pulse);

   // combined power-down: pin low wins over anything programmed
   wire pd_any = ~ce_s | (pwr == SCL_PWR_DOWN);

   // timeout in comparator cycles: base plus four per code step
   wire [5:0] to_cycles = SCL_TO_BASE + 6'({func.timeout, 2'h0});

   // fast acquisition, gain bit lives in the feedback payload
   wire gain = fb_latch_word[SCL_POS_GAIN];
   wire fa_on = func.fa_en & gain;
   wire fb_sets_gain = load_fb & payload[SCL_POS_GAIN];
   // a fresh load that sets the gain must not be undone by expiry
   wire fa_expire = fa_run & cyc_rise & (fa_count == 6'h01) & ~pd_any;

   // a load with the request bit clear always powers up, even while waiting
   // for a pump event; a new request load restarts the decision from scratch
   // limitation: the pin is not part of this state, it is merged in pd_any
   // power state decision on a function or init load
   always_comb begin
      next_pwr = pwr;
      if (load_func) begin
         if (!new_func.pd_req) begin
            next_pwr = SCL_PWR_ON;
         end else if (!new_func.pd_sync) begin
            next_pwr = SCL_PWR_DOWN;
         end else if (load_init && ce_s) begin
            next_pwr = SCL_PWR_DOWN;
         end else begin
            next_pwr = SCL_PWR_WAIT;
         end
      end else begin
         case (pwr)
            SCL_PWR_ON: begin
               next_pwr = SCL_PWR_ON;
            end
            SCL_PWR_WAIT: begin
               // the hold bit plays no part here: it never forces this
               if (pump_rise) begin
                  next_pwr = SCL_PWR_DOWN;
               end
            end
            SCL_PWR_DOWN: begin
               next_pwr = SCL_PWR_DOWN;
            end
            default: begin
               next_pwr = SCL_PWR_ON;
            end
         endcase
      end
   end

   // edge memories
   // reset values match the idle low level of each pin, so no false edge
   // appears in the first cycles after reset
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         le_d <= 1'b0;
         pump_d <= 1'b0;
         cyc_d <= 1'b0;
      end else begin
         le_d <= le_s;
         pump_d <= pump_s;
         cyc_d <= cyc_s;
      end
   end

   // function settings and power state; input register stays live in power-down
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         func <= SCL_FUNC_RST;
         pwr <= SCL_PWR_ON;
      end else begin
         if (load_func) begin
            func <= new_func;
         end
         pwr <= next_pwr;
      end
   end

   // the reference payload is only passed on to the counter datapath;
   // it keeps loading even while powered down
   // reference latch copy
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_latch_word <= '0;
      end else if (load_ref) begin
         ref_latch_word <= payload;
      end
   end

   // the gain bit is the only field that hardware touches on its own;
   // the rest of the payload only changes on a feedback load
   // feedback latch; a load wins over the self-clear of the gain bit
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fb_latch_word <= '0;
      end else if (load_fb) begin
         fb_latch_word <= payload;
      end else if (fa_expire) begin
         fb_latch_word[SCL_POS_GAIN] <= 1'b0;
      end
   end

   // the arm flag is set by every init load and spent by the next feedback
   // load, so a second feedback load after one init does not pulse again;
   // the pulse itself is one sys_clk cycle long
   // init bookkeeping and the reset pulse
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_fb_pulse <= 1'b0;
         rst_pulse <= 1'b0;
      end else begin
         rst_pulse <= next_rst_pulse;
         if (load_init) begin
            arm_fb_pulse <= 1'b1;
         end else if (load_fb) begin
            arm_fb_pulse <= 1'b0;
         end
      end
   end

   // count the comparator cycles down from the programmed length; expiry is
   // taken on the rise at which the count reads one, so the high current
   // lasts exactly the programmed number of comparator cycles
   // timed exit counter; reloads while powered down or on the reset pulse
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fa_count <= SCL_TO_BASE;
         fa_run <= 1'b0;
      end else if (fb_sets_gain && func.fa_en && func.fa_mode) begin
         fa_count <= to_cycles;
         fa_run <= 1'b1;
      end else if (load_fb || fa_expire) begin
         fa_run <= 1'b0;
      end else if (pd_any || rst_pulse) begin
         fa_count <= to_cycles;
      end else if (fa_run && cyc_rise) begin
         fa_count <= fa_count - 6'h01;
      end
   end

   // sources are synchronised levels, so the pin shows them three sys_clk
   // cycles late; fine for lock and divider monitoring, not for timing
   // observe decode: {drive value, oe_b}; open-drain only pulls low
   wire [1:0] obs_pick =
      (func.obs_sel == SCL_OBS_LOCK) ? {lock_s, 1'b0} :
      (func.obs_sel == SCL_OBS_FB) ? {fb_s, 1'b0} :
      (func.obs_sel == SCL_OBS_REF) ? {ref_s, 1'b0} :
      (func.obs_sel == SCL_OBS_LOCK_OD) ? {1'b0, lock_s} :
      (func.obs_sel == SCL_OBS_SDO) ? {sdo_s, 1'b0} :
      (func.obs_sel == SCL_OBS_GND) ? 2'h0 :
      2'h1; // three-state and spare code float the pin

   // switch output: follows the mode bit when disabled, low while active
   wire next_lfs = func.fa_en ? ~fa_on : func.fa_mode;

   // pump controls; hold and pulse float the pump like a power-down
   wire scl_pump_s next_pump = '{
      tristate: func.pump_tri | func.hold | pd_any | rst_pulse,
      high_current: gain,
      positive: func.polarity
   };

   // every output is a flop: one cycle of latency is traded for glitch-free
   // levels at the counter datapath and the pump, which see them directly
   // reset values describe a powered-down device with a floating pump
   // registered outputs
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pump_ctrl <= SCL_PUMP_RST;
         counter_reset <= 1'b1;
         timeout_reload <= 1'b1;
         powered_down <= 1'b1;
         lock_detect_reset <= 1'b1;
         fast_active <= 1'b0;
         loop_filter_switch_out <= 1'b0;
         observe_output <= 1'b0;
         observe_oe_b <= 1'b1;
      end else begin
         pump_ctrl <= next_pump;
         counter_reset <= func.hold | pd_any | rst_pulse;
         timeout_reload <= pd_any | rst_pulse;
         powered_down <= pd_any;
         lock_detect_reset <= pd_any;
         fast_active <= fa_on;
         loop_filter_switch_out <= next_lfs;
         observe_output <= obs_pick[1];
         observe_oe_b <= obs_pick[0];
      end
   end
endmodule

// file: tb/scl_host.sv
/*
 * scl_host: host model on the three-wire link; sends whole 21-bit frames.
 * assumes: frames are spaced by the caller; the link clock idles low.
 */
`timescale 1ns/100ps
module scl_host (
   output logic ser_clk,
   output logic ser_data,
   output logic load_strobe
);
   // idle link: clock still, strobe low
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      load_strobe = 1'b0;
   end
   // odd start offset keeps the 80 ns link clock off the system phase
   task automatic send(input logic [20:0] w);
      #13.3;
      for (int i = 20; i >= 0; i--) begin
         ser_data = w[i];
         #40 ser_clk = 1'b1;
         #40 ser_clk = 1'b0;
      end
      #40 load_strobe = 1'b1;
      ser_data = ~w[0]; // released data line must not show the last bit
      #60 load_strobe = 1'b0;
   endtask
endmodule

// file: tb/scl_latch_ctrl_checker.sv
/*
 * scl_latch_ctrl_checker: port-level properties of the control latches.
 * assumes: bound to scl_latch_ctrl; all outputs are sys_clk registers.
 */
`timescale 1ns/100ps
module scl_latch_ctrl_checker (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic load_strobe,
   input wire logic power_enable,
   input wire scl_pkg::scl_pump_s pump_ctrl,
   input wire logic counter_reset,
   input wire logic timeout_reload,
   input wire logic powered_down,
   input wire logic lock_detect_reset,
   input wire logic fast_active,
   input wire logic loop_filter_switch_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   ldr_follow_a: assert property (lock_detect_reset == powered_down)
      else $error("lock detect reset differs from power state");
   pd_forces_a: assert property (powered_down |-> counter_reset && timeout_reload && pump_ctrl.tristate)
      else $error("power-down left counters or pump active");
   pin_down_a: assert property (!power_enable [*4] |-> powered_down)
      else $error("pin low did not power down");
   pin_up_a: assert property ($fell(powered_down) |-> $past(power_enable, 2))
      else $error("powered up with pin low");
   hold_tri_a: assert property (counter_reset |-> pump_ctrl.tristate)
      else $error("counter reset without pump three-state");
   fast_out_a: assert property (fast_active |-> pump_ctrl.high_current && !loop_filter_switch_out)
      else $error("fast acquisition outputs wrong");
   pol_quiet_a: assert property (!load_strobe [*8] |=> $stable(pump_ctrl.positive))
      else $error("polarity changed without a load");
   gain_quiet_a: assert property (!load_strobe [*8] |=> !$rose(pump_ctrl.high_current))
      else $error("pump current raised without a load");
   // main scenarios reached
   cover property ($rose(fast_active));
   cover property ($fell(fast_active));
   cover property ($rose(powered_down) && power_enable);
endmodule
bind scl_latch_ctrl scl_latch_ctrl_checker chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
   .load_strobe(load_strobe), .power_enable(power_enable), .pump_ctrl(pump_ctrl),
   .counter_reset(counter_reset), .timeout_reload(timeout_reload), .powered_down(powered_down),
   .lock_detect_reset(lock_detect_reset), .fast_active(fast_active),
   .loop_filter_switch_out(loop_filter_switch_out));

// file: tb/scl_latch_ctrl_bench.sv
/*
 * scl_latch_ctrl_bench: self-checking bench for the control latches.
 * assumes: scl_host drives the link; pins are driven at sys_clk falling edge.
 */
`timescale 1ns/100ps
module scl_latch_ctrl_bench;
   import scl_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic power_enable = 1'b0;
   logic ref_div_in = 1'b0;
   logic pump_event_in = 1'b0;
   logic pd_cycle_in = 1'b0;
   logic fb_div_in = 1'b0;
   logic lock_detect_in = 1'b0;
   logic ser_clk, ser_data, load_strobe;
   logic [18:0] ref_w, fb_w;
   scl_pump_s pump_ctrl;
   logic counter_reset, timeout_reload, powered_down, lock_detect_reset;
   logic fast_active, loop_filter_switch_out, observe_output, observe_oe_b;
   int n_mismatch = 0;
   int num_checks = 0;
   int n_pulse = 0; // cycles seen with counter reset high
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (counter_reset) n_pulse++;
   scl_host host_u (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));
   scl_latch_ctrl dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .ser_clk(ser_clk), .ser_data(ser_data),
      .load_strobe(load_strobe), .power_enable(power_enable), .ref_div_in(ref_div_in),
      .fb_div_in(fb_div_in), .lock_detect_in(lock_detect_in), .pump_event_in(pump_event_in),
      .pd_cycle_in(pd_cycle_in), .ref_latch_word(ref_w), .fb_latch_word(fb_w),
      .pump_ctrl(pump_ctrl), .counter_reset(counter_reset), .timeout_reload(timeout_reload),
      .powered_down(powered_down), .lock_detect_reset(lock_detect_reset),
      .fast_active(fast_active), .loop_filter_switch_out(loop_filter_switch_out),
      .observe_output(observe_output), .observe_oe_b(observe_oe_b));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // a frame plus room for sync and output flops
   task automatic ld(input logic [20:0] w);
      host_u.send(w);
      cyc(8);
   endtask
   task automatic pcyc(input int n);
      repeat (n) begin
         pd_cycle_in = 1'b1;
         cyc(3);
         pd_cycle_in = 1'b0;
         cyc(3);
      end
   endtask
   task automatic t_basic();
      chk({pump_ctrl, powered_down, observe_oe_b}, 5'h01);
      ld(21'h0000E2);
      chk({pump_ctrl.positive, observe_oe_b, observe_output}, 3'h4);
      ld(21'h000032);
      ref_div_in = 1'b1;
      cyc(5);
      chk({observe_oe_b, observe_output}, 2'h1);
      ref_div_in = 1'b0;
      fb_div_in = 1'b1;
      ld(21'h000022);
      chk({observe_oe_b, observe_output}, 2'h1);
      fb_div_in = 1'b0;
      lock_detect_in = 1'b1;
      ld(21'h000012);
      chk({observe_oe_b, observe_output}, 2'h1);
      ld(21'h000042);
      chk(observe_oe_b, 1'b1);
      lock_detect_in = 1'b0;
      cyc(5);
      chk({observe_oe_b, observe_output}, 2'h0);
      ld(21'h000102);
      chk(pump_ctrl, 3'h4);
      ld(21'h000802);
      chk(loop_filter_switch_out, 1'b1);
      ld(21'h000002);
      chk({loop_filter_switch_out, pump_ctrl}, 4'h0);
      $display("basic done");
   endtask
   task automatic t_hold();
      ld(21'h000006);
      chk({counter_reset, pump_ctrl.tristate, powered_down}, 3'h6);
      ld(21'h000002);
      chk(counter_reset, 1'b0);
      $display("hold done");
   endtask
   task automatic t_pdown();
      ld(21'h00000A);
      chk({powered_down, counter_reset, timeout_reload, lock_detect_reset}, 4'hF);
      ld(21'h000002);
      ld(21'h08000A);
      chk(powered_down, 1'b0);
      pump_event_in = 1'b1;
      cyc(3);
      pump_event_in = 1'b0;
      cyc(4);
      chk(powered_down, 1'b1);
      ld(21'h000002);
      $display("power-down done");
   endtask
   task automatic t_pin();
      power_enable = 1'b0;
      cyc(4);
      chk({powered_down, pump_ctrl.tristate}, 2'h3);
      ld(21'h000082);
      ld(21'h000000);
      ld(21'h000001);
      chk(powered_down, 1'b1);
      power_enable = 1'b1;
      cyc(100);
      chk({powered_down, pump_ctrl}, 4'h1);
      $display("pin done");
   endtask
   task automatic t_init();
      n_pulse = 0;
      ld(21'h000003);
      chk(n_pulse, 1);
      ld(21'h0ABCD0);
      chk(ref_w, 19'h2AF34);
      ld(21'h000001);
      ld(21'h000001);
      chk(n_pulse, 2);
      ld(21'h08000B);
      chk(powered_down, 1'b1);
      ld(21'h000002);
      $display("init done");
   endtask
   task automatic t_fast();
      ld(21'h100001);
      chk({fast_active, pump_ctrl.high_current}, 2'h1);
      chk(fb_w, 19'h40000);
      ld(21'h000001);
      ld(21'h000202);
      chk({fast_active, loop_filter_switch_out}, 2'h1);
      ld(21'h100001);
      pcyc(8);
      chk({fast_active, pump_ctrl.high_current, loop_filter_switch_out}, 3'h6);
      ld(21'h000001);
      chk(fast_active, 1'b0);
      ld(21'h001A02);
      ld(21'h100001);
      pcyc(6);
      chk(pump_ctrl.high_current, 1'b1);
      pcyc(1);
      chk({pump_ctrl.high_current, fb_w[SCL_POS_GAIN]}, 2'h0);
      $display("fast done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // main sequence: reset for three cycles, then each scenario
   initial begin
      cyc(3);
      rst_b = 1'b1;
      power_enable = 1'b1;
      cyc(6);
      t_basic();
      t_hold();
      t_pdown();
      t_pin();
      t_init();
      t_fast();
      complete_run();
   end
   // watchdog: the scenarios need well under 100 us
   initial begin
      #400000;
      n_mismatch++;
      complete_run();
   end
endmodule
